// ===== rtl/adc_pkg.sv
// Purpose: constants for the daisy-chain converter readout
// Assumes: one system clock, link clock sampled as a plain input
// Notes: conversion time is a count of system clock cycles
package adc_pkg;
   localparam int unsigned ADC_RES_BITS = 16;
   localparam real ADC_CLK_MHZ = 100.0;
   localparam real ADC_CONV_NS = 1600.0;
   localparam int unsigned ADC_CONV_CYC = int'($ceil(ADC_CONV_NS * ADC_CLK_MHZ / 1000.0));
   localparam logic [15:0] ADC_SAMPLE_RST = 16'h0000;

   typedef enum logic [1:0] {
      ADC_ST_IDLE = 2'b00,
      ADC_ST_CONV = 2'b01,
      ADC_ST_WAIT = 2'b10,
      ADC_ST_READ = 2'b11
   } adc_state_t;
endpackage : adc_pkg

// ===== rtl/adc_chain_readout.sv
// Purpose: serial result readout of one converter in busy-indicator chain mode
// Assumes: start, clock and chain input come from outside and are synchronised here
// Notes: analogue conversion replaced by a timer and a sample input
//
// ****************************************
// Frame walk
// ****************************************
// Start rises with serial clock high: two to three cycles of sync latency,
// then the conversion timer runs for CONV_CYCLES system clocks.
// On the last timer cycle the sample is loaded into the shift register.
// The device then waits until its chain input is high, meaning every
// upstream converter is done too, and drives its serial output high.
// Each serial clock falling edge then puts the next bit out, MSB first,
// while the chain input level enters the low end of the register.
// After sixteen own bits the upstream bits follow through the register.
// Start going low during readout ends the frame and returns the sequencer to idle.
//
// Hazards
// Serial clock edges are found on the system clock, so the link clock
// must stay well below half the system clock rate.
// Starts seen outside idle are ignored; a running frame is never restarted.
module adc_chain_readout
   import adc_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = ADC_CONV_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_conversion_start,
   input wire logic i_serial_clock,
   input wire logic i_serial_chain_in,
   input wire logic [15:0] i_sample,
   output logic o_serial_result_out,
   output logic o_low_power,
   output logic o_busy
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] cnv_meta, sck_meta, sdi_meta;
   logic cnv_s, sck_s, sdi_s, cnv_d, sck_d;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnv_meta <= 2'h0;
         sck_meta <= 2'h0;
         sdi_meta <= 2'h0;
         cnv_d <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         cnv_meta <= {cnv_meta[0], i_conversion_start};
         sck_meta <= {sck_meta[0], i_serial_clock};
         sdi_meta <= {sdi_meta[0], i_serial_chain_in};
         cnv_d <= cnv_meta[1];
         sck_d <= sck_meta[1];
      end
   end
   assign cnv_s = cnv_meta[1];
   assign sck_s = sck_meta[1];
   assign sdi_s = sdi_meta[1];

   logic cnv_rise, sck_fall;
   assign cnv_rise = cnv_s && !cnv_d;
   assign sck_fall = !sck_s && sck_d;

   // ****************************************
   // Conversion sequencer
   // ****************************************
   adc_state_t state;
   adc_state_t next_state;
   logic [31:0] conv_cnt;
   logic [15:0] shreg;
   logic serial_result_out;
   logic started;
   logic start_ok;
   logic conv_done;
   logic upstream_done;
   logic shift_now;

   // Last cycle of the conversion timer
   function automatic logic is_conv_end(input adc_state_t st, input logic [31:0] cnt);
      return (st == ADC_ST_CONV) && (cnt == CONV_CYCLES - 1);
   endfunction

   // Start taken only with the serial clock high
   assign start_ok = cnv_rise && sck_s;
   assign conv_done = is_conv_end(state, conv_cnt);
   // Own conversion over and every upstream device done
   assign upstream_done = (state == ADC_ST_WAIT) && sdi_s;
   // One shift per serial clock falling edge while reading
   assign shift_now = (state == ADC_ST_READ) && sck_fall;

   // Next-state decode
   always_comb begin
      next_state = state;
      unique case (state)
         ADC_ST_IDLE: begin
            if (start_ok) begin
               next_state = ADC_ST_CONV;
            end
         end
         ADC_ST_CONV: begin
            if (conv_done) begin
               next_state = ADC_ST_WAIT;
            end
         end
         ADC_ST_WAIT: begin
            // Busy ends once upstream has also finished
            if (upstream_done) begin
               next_state = ADC_ST_READ;
            end
         end
         ADC_ST_READ: begin
            // Start line low closes the frame
            if (!cnv_s) begin
               next_state = ADC_ST_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= ADC_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Conversion timer, cleared on each accepted start
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         conv_cnt <= 32'h0;
      end else if (state == ADC_ST_IDLE && start_ok) begin
         conv_cnt <= 32'h0;
      end else if (state == ADC_ST_CONV && !conv_done) begin
         conv_cnt <= conv_cnt + 32'h1;
      end
   end

   // Frame active flag, feeds the busy indicator
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         started <= 1'b0;
      end else if (state == ADC_ST_IDLE && start_ok) begin
         started <= 1'b1;
      end else if (state == ADC_ST_READ && !cnv_s) begin
         started <= 1'b0;
      end
   end

   // ****************************************
   // Shift register: load, shift and pass-through
   // ****************************************
   // Sample captured at the end of conversion, then shifted per falling edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shreg <= ADC_SAMPLE_RST;
      end else if (conv_done) begin
         shreg <= i_sample;
      end else if (shift_now) begin
         shreg <= {shreg[ADC_RES_BITS-2:0], sdi_s};
      end
   end

   // Serial output bit: low while waiting, high when done, then data
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         serial_result_out <= 1'b0;
      end else if (conv_done) begin
         serial_result_out <= 1'b0;
      end else if (upstream_done) begin
         serial_result_out <= 1'b1;
      end else if (shift_now) begin
         serial_result_out <= shreg[ADC_RES_BITS-1];
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      if (!cnv_s && !sdi_s) begin
         o_serial_result_out = 1'b0;
      end else if (state == ADC_ST_IDLE) begin
         o_serial_result_out = 1'b0;
      end else begin
         o_serial_result_out = serial_result_out;
      end
   end
   // Low power everywhere but the conversion itself
   // Acquisition and readout both count as the quiet phase
   assign o_low_power = (state != ADC_ST_CONV);
   // Busy from accepted start until the chain reports done
   assign o_busy = (state == ADC_ST_CONV) || (started && state == ADC_ST_WAIT);
endmodule : adc_chain_readout

// ===== dv/adc_host_model.sv
// Purpose: host model. Assumes: 160 ns link clock. Notes: clock idles high
module adc_host (output logic o_cnv = 1'h0, output logic o_sck = 1'h1);
   timeunit 1ns;
   timeprecision 1ns;
   task start(input logic lvl);
      o_sck = lvl;
      #80 o_cnv = 1'h1;
   endtask
   task pulse();
      #80 o_sck = 1'h0;
      #80 o_sck = 1'h1;
   endtask
endmodule // adc_host

// ===== dv/adc_checker.sv
// Purpose: port checks. Assumes: start synchronised. Notes: bind below
module adc_checker #(
   parameter int CONV = 160
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_conversion_start,
   input wire logic i_serial_clock,
   input wire logic i_serial_chain_in,
   input wire logic o_serial_result_out,
   input wire logic o_low_power,
   input wire logic o_busy
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_start_cause: assert property ($rose(o_busy) |-> $past(i_conversion_start, 2))
      else $error("busy with no start");
   a_sck_high: assert property ($rose(o_busy) |-> $past(i_serial_clock, 3))
      else $error("start taken with serial clock low");
   a_conv_bound: assert property ($fell(o_low_power) |-> ##CONV $rose(o_low_power))
      else $error("conversion length wrong");
   a_conv_busy: assert property (!o_low_power |-> o_busy)
      else $error("converting while not busy");
   a_done_high: assert property ($fell(o_busy) && $past(i_conversion_start, 2) |-> o_serial_result_out)
      else $error("done not shown high");
   a_idle_low: assert property (!$past(i_conversion_start, 2) && !$past(i_serial_chain_in, 2)
      |-> !o_serial_result_out)
      else $error("output not low with start and chain in low");
endmodule // adc_checker
bind adc_chain_readout adc_checker #(.CONV(CONV_CYCLES)) chk_i (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_conversion_start(i_conversion_start), .i_serial_clock(i_serial_clock),
   .i_serial_chain_in(i_serial_chain_in), .o_serial_result_out(o_serial_result_out),
   .o_low_power(o_low_power), .o_busy(o_busy));

// ===== dv/tb.sv
// Purpose: readout bench. Assumes: one device. Notes: 8-cycle conversion
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, nrst = 1'h0, serial_chain_in = 1'h1, out, busy, conversion_start, sck, lp;
   logic [15:0] smp = 16'ha5c3;
   int errors = 0, n_tests = 0;
   adc_host h (.o_cnv(conversion_start), .o_sck(sck));
   adc_chain_readout #(.CONV_CYCLES(8)) DUT (.i_clk(clk), .i_nrst(nrst), .i_sample(smp),
      .i_conversion_start(conversion_start), .i_serial_clock(sck), .i_serial_chain_in(serial_chain_in),
      .o_serial_result_out(out), .o_low_power(lp), .o_busy(busy));
   task chk(string nm, logic e, logic s);
      n_tests++;
      errors += int'(s !== e);
      if (s !== e) $display("CHECK FAILED %s exp %b got %b", nm, e, s);
   endtask
   task close_out();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task t_refuse();
      h.start(1'h0);
      #200 chk("busy", 1'h0, busy);
      chk("low_power", 1'h1, lp);
      h.o_cnv = 1'h0;
   endtask
   task t_frame();
      h.start(1'h1);
      #80 chk("busy", 1'h1, busy);
      chk("low_power", 1'h0, lp);
      #180 chk("done", 1'h1, out);
      chk("busy_end", 1'h0, busy);
      chk("low_power", 1'h1, lp);
      for (int k = 15; k >= -1; k--) begin
         h.pulse();
         chk("bit", k < 0 ? serial_chain_in : smp[k], out);
      end
      h.o_cnv = 1'h0;
      serial_chain_in = 1'h0;
      #100 chk("idle", 1'h0, out);
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      repeat (5) @(posedge clk);
      #1 nrst = 1'h1;
      t_refuse();
      t_frame();
      close_out();
   end
   initial begin
      #20000 errors++;
      close_out();
   end
endmodule // tb
